// [shared/fia_pkg.sv]
// Constants shared by the fault interrupt aggregator and its input filter.
// Assumes a single 25 MHz clock domain and a word-wide AHB-Lite register bus.
package fia_pkg;

   // Clock and timing.
   localparam int CLK_PERIOD_NS  = 40;
   localparam int FILTER_SPAN_NS = 120;
   localparam int FILTER_STAGES  = (FILTER_SPAN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RELEASE_NS     = 40;
   localparam int RELEASE_RAW    = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RELEASE_CYC    = (RELEASE_RAW < 1) ? 1 : RELEASE_RAW;
   localparam logic [1:0] RELEASE_LOAD = 2'(RELEASE_CYC);

   // Register indices; the byte address is four times the index.
   localparam logic [5:0] IDX_INVA_STAT = 6'h00;
   localparam logic [5:0] IDX_INVA_EN   = 6'h01;
   localparam logic [5:0] IDX_INVB_STAT = 6'h02;
   localparam logic [5:0] IDX_INVB_EN   = 6'h03;
   localparam logic [5:0] IDX_HB_STAT   = 6'h04;
   localparam logic [5:0] IDX_HB_EN     = 6'h05;
   localparam logic [5:0] IDX_SYS_STAT  = 6'h06;
   localparam logic [5:0] IDX_SYS_EN    = 6'h07;
   localparam logic [5:0] IDX_LED_CTRL  = 6'h30;
   localparam logic [5:0] IDX_SRC_LEVEL = 6'h31;

   // Field widths.
   localparam int INV_W = 4;
   localparam int HB_W  = 2;
   localparam int SYS_W = 5;
   localparam int GPI_W = 4;
   localparam int SRC_W = 15;
   localparam int LINES = 4;

   // Bit positions inside the status and enable registers.
   localparam int INV_OVT_BIT   = 0;
   localparam int INV_ERR_W_BIT = 1;
   localparam int INV_ERR_V_BIT = 2;
   localparam int INV_ERR_U_BIT = 3;
   localparam int HB_OVT_BIT    = 0;
   localparam int HB_ERR_BIT    = 1;
   localparam int SYS_RLY_BIT   = 0;
   localparam int SYS_GPI_LSB   = 1;

   // Positions inside the filtered source vector.
   localparam int SRC_INVA_LSB = 0;
   localparam int SRC_INVB_LSB = 4;
   localparam int SRC_HB_LSB   = 8;
   localparam int SRC_RLY_BIT  = 10;
   localparam int SRC_GPI_LSB  = 11;

   // Interrupt line order.
   localparam int LINE_INVA = 0;
   localparam int LINE_INVB = 1;
   localparam int LINE_HB   = 2;
   localparam int LINE_SYS  = 3;

   // Values after reset.
   localparam logic [SRC_W-1:0] SRC_IDLE      = 15'h0400;
   localparam logic [INV_W-1:0] INV_RST       = 4'h0;
   localparam logic [HB_W-1:0]  HB_RST        = 2'h0;
   localparam logic [SYS_W-1:0] SYS_RST       = 5'h00;
   localparam logic             LED_FORCE_RST = 1'b0;

endpackage : fia_pkg

// [core/fia_glitch_filter.sv]
// Input synchroniser and three-sample glitch filter, one lane per source bit.
// Assumes asynchronous pins; the stored level resets to each lane's idle value.
`timescale 1ns/1ps
module fia_glitch_filter #(
   parameter int             W     = 4,
   parameter int             DEPTH = 3,
   parameter logic [W-1:0]   IDLE  = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] level,
   output logic      [W-1:0] changed
);

   typedef struct packed {
      logic [W-1:0]            s1;
      logic [W-1:0]            s2;
      logic [W-1:0][DEPTH-1:0] chain;
      logic [W-1:0]            level;
      logic [W-1:0]            changed;
   } fia_flt_t;

   function automatic logic [W-1:0][DEPTH-1:0] fill_chain(input logic [W-1:0] v);
      logic [W-1:0][DEPTH-1:0] r;
      for (int k = 0; k < W; k++) begin
         r[k] = {DEPTH{v[k]}};
      end
      return r;
   endfunction : fill_chain

   localparam fia_flt_t FLT_RST = '{s1: IDLE, s2: IDLE, chain: fill_chain(IDLE),
                                    level: IDLE, changed: '0};

   fia_flt_t                q;
   fia_flt_t                d;
   logic [W-1:0][DEPTH-1:0] chain_nxt;
   logic [W-1:0]            accept;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   for (genvar i = 0; i < W; i++) begin : g_bit
      assign chain_nxt[i] = {q.chain[i][DEPTH-2:0], q.s2[i]};
      assign accept[i]    = q.level[i] ? ~|q.chain[i] : &q.chain[i];

      a_filter_agree: assert property (
         $changed(q.level[i]) |-> $past(q.chain[i]) == {DEPTH{q.level[i]}})
         else $error("Filtered level moved without agreeing samples.");
      a_filter_delay: assert property (
         $changed(q.level[i]) |-> $past(q.s2[i], 2) == q.level[i]
            && $past(q.s2[i], 3) == q.level[i] && $past(q.s2[i], 4) == q.level[i])
         else $error("Filtered level moved sooner than three samples.");
   end

   always_comb begin
      d         = q;
      d.s1      = pin_in;
      d.s2      = q.s1;
      d.chain   = chain_nxt;
      d.level   = q.level ^ accept;
      d.changed = accept;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= FLT_RST;
      end else begin
         q <= d;
      end
   end

   assign level   = q.level;
   assign changed = q.changed;

endmodule : fia_glitch_filter

// [core/fia_fault_aggregator.sv]
// Fault latching and interrupt generation with an AHB-Lite register slave.
// Assumes one 25 MHz clock, fault pins asynchronous to it, word-only transfers.
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module fia_fault_aggregator #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              hsel,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire logic              inva_ovt,
   input  wire logic              inva_err_u,
   input  wire logic              inva_err_v,
   input  wire logic              inva_err_w,
   input  wire logic              invb_ovt,
   input  wire logic              invb_err_u,
   input  wire logic              invb_err_v,
   input  wire logic              invb_err_w,
   input  wire logic              hb_ovt,
   input  wire logic              hb_err,
   input  wire logic              relay_fault_n,
   input  wire logic [3:0]        gpi,
   output logic                   inva_irq_out_n,
   output logic                   invb_irq_out_n,
   output logic                   half_bridge_irq_out_n,
   output logic                   sys_irq_out_n,
   output logic                   inva_fault_lamp,
   output logic                   invb_fault_lamp,
   output logic                   half_bridge_fault_lamp,
   output logic                   sys_fault_lamp
);

   typedef struct packed {
      logic                           wr_pend;
      logic [5:0]                     wr_idx;
      logic [fia_pkg::INV_W-1:0]      inva_stat;
      logic [fia_pkg::INV_W-1:0]      inva_en;
      logic [fia_pkg::INV_W-1:0]      invb_stat;
      logic [fia_pkg::INV_W-1:0]      invb_en;
      logic [fia_pkg::HB_W-1:0]       hb_stat;
      logic [fia_pkg::HB_W-1:0]       hb_en;
      logic [fia_pkg::SYS_W-1:0]      sys_stat;
      logic [fia_pkg::SYS_W-1:0]      sys_en;
      logic                           led_force;
      logic [fia_pkg::LINES-1:0][1:0] rel_cnt;
      logic [fia_pkg::LINES-1:0]      irq_n;
      logic [fia_pkg::LINES-1:0]      lamp;
      logic [31:0]                    hrdata;
      logic                           hreadyout;
   } fia_state_t;

   localparam fia_state_t ST_RST = '{
      wr_pend:   1'b0,
      wr_idx:    6'h00,
      inva_stat: fia_pkg::INV_RST,
      inva_en:   fia_pkg::INV_RST,
      invb_stat: fia_pkg::INV_RST,
      invb_en:   fia_pkg::INV_RST,
      hb_stat:   fia_pkg::HB_RST,
      hb_en:     fia_pkg::HB_RST,
      sys_stat:  fia_pkg::SYS_RST,
      sys_en:    fia_pkg::SYS_RST,
      led_force: fia_pkg::LED_FORCE_RST,
      rel_cnt:   '0,
      irq_n:     4'hF,
      lamp:      4'h0,
      hrdata:    32'h0000_0000,
      hreadyout: 1'b1
   };

   fia_state_t                 q;
   fia_state_t                 d;
   logic [fia_pkg::SRC_W-1:0]  src_pin;
   logic [fia_pkg::SRC_W-1:0]  flt_lvl;
   logic [fia_pkg::SRC_W-1:0]  flt_chg;
   logic [fia_pkg::INV_W-1:0]  inva_ev;
   logic [fia_pkg::INV_W-1:0]  invb_ev;
   logic [fia_pkg::HB_W-1:0]   hb_ev;
   logic [fia_pkg::SYS_W-1:0]  sys_ev;
   logic [fia_pkg::INV_W-1:0]  inva_clr;
   logic [fia_pkg::INV_W-1:0]  invb_clr;
   logic [fia_pkg::HB_W-1:0]   hb_clr;
   logic [fia_pkg::SYS_W-1:0]  sys_clr;
   logic [fia_pkg::LINES-1:0]  clr_hit;
   logic [fia_pkg::LINES-1:0]  line_act;
   logic                       addr_ok;
   logic                       wr_now;

   // Source vector: phase errors sit above the over-temperature bit of each bridge.
   assign src_pin = {gpi, relay_fault_n, hb_err, hb_ovt,
                     invb_err_u, invb_err_v, invb_err_w, invb_ovt,
                     inva_err_u, inva_err_v, inva_err_w, inva_ovt};

   fia_glitch_filter #(
      .W     (fia_pkg::SRC_W),
      .DEPTH (fia_pkg::FILTER_STAGES),
      .IDLE  (fia_pkg::SRC_IDLE)
   ) u_filter (
      .clk     (clk),
      .rst     (rst),
      .pin_in  (src_pin),
      .level   (flt_lvl),
      .changed (flt_chg)
   );

   // Bridge faults count on a rising level, the relay fault on a falling one.
   assign inva_ev = flt_chg[fia_pkg::SRC_INVA_LSB +: 4] & flt_lvl[fia_pkg::SRC_INVA_LSB +: 4];
   assign invb_ev = flt_chg[fia_pkg::SRC_INVB_LSB +: 4] & flt_lvl[fia_pkg::SRC_INVB_LSB +: 4];
   assign hb_ev   = flt_chg[fia_pkg::SRC_HB_LSB +: 2] & flt_lvl[fia_pkg::SRC_HB_LSB +: 2];
   assign sys_ev  = {flt_chg[fia_pkg::SRC_GPI_LSB +: 4],
                     flt_chg[fia_pkg::SRC_RLY_BIT] & ~flt_lvl[fia_pkg::SRC_RLY_BIT]};

   always_comb begin
      d           = q;
      d.hreadyout = 1'b1;
      d.hrdata    = 32'h0000_0000;
      addr_ok     = hsel && hready && htrans[1];
      d.wr_pend   = addr_ok && hwrite;
      d.wr_idx    = haddr[7:2];
      wr_now      = q.wr_pend;

      // A written zero clears a status bit; a written one leaves it alone.
      inva_clr = (wr_now && q.wr_idx == fia_pkg::IDX_INVA_STAT) ? ~hwdata[3:0] : 4'h0;
      invb_clr = (wr_now && q.wr_idx == fia_pkg::IDX_INVB_STAT) ? ~hwdata[3:0] : 4'h0;
      hb_clr   = (wr_now && q.wr_idx == fia_pkg::IDX_HB_STAT) ? ~hwdata[1:0] : 2'h0;
      sys_clr  = (wr_now && q.wr_idx == fia_pkg::IDX_SYS_STAT) ? ~hwdata[4:0] : 5'h00;

      // Events win over a clear in the same cycle.
      d.inva_stat = (q.inva_stat & ~inva_clr) | inva_ev;
      d.invb_stat = (q.invb_stat & ~invb_clr) | invb_ev;
      d.hb_stat   = (q.hb_stat & ~hb_clr) | hb_ev;
      d.sys_stat  = (q.sys_stat & ~sys_clr) | sys_ev;

      clr_hit[fia_pkg::LINE_INVA] = |(q.inva_stat & inva_clr);
      clr_hit[fia_pkg::LINE_INVB] = |(q.invb_stat & invb_clr);
      clr_hit[fia_pkg::LINE_HB]   = |(q.hb_stat & hb_clr);
      clr_hit[fia_pkg::LINE_SYS]  = |(q.sys_stat & sys_clr);

      if (wr_now) begin
         case (q.wr_idx)
            fia_pkg::IDX_INVA_EN:  d.inva_en   = hwdata[3:0];
            fia_pkg::IDX_INVB_EN:  d.invb_en   = hwdata[3:0];
            fia_pkg::IDX_HB_EN:    d.hb_en     = hwdata[1:0];
            fia_pkg::IDX_SYS_EN:   d.sys_en    = hwdata[4:0];
            fia_pkg::IDX_LED_CTRL: d.led_force = hwdata[0];
            default:               d.led_force = q.led_force;
         endcase
      end

      // Status latches regardless of enables; enables gate only the line.
      line_act[fia_pkg::LINE_INVA] = |(d.inva_stat & d.inva_en);
      line_act[fia_pkg::LINE_INVB] = |(d.invb_stat & d.invb_en);
      line_act[fia_pkg::LINE_HB]   = |(d.hb_stat & d.hb_en);
      line_act[fia_pkg::LINE_SYS]  = |(d.sys_stat & d.sys_en);

      for (int k = 0; k < fia_pkg::LINES; k++) begin
         if (clr_hit[k]) begin
            d.rel_cnt[k] = fia_pkg::RELEASE_LOAD;
         end else if (q.rel_cnt[k] != 2'h0) begin
            d.rel_cnt[k] = q.rel_cnt[k] - 2'h1;
         end else begin
            d.rel_cnt[k] = 2'h0;
         end
         d.irq_n[k] = (d.rel_cnt[k] != 2'h0) ? 1'b1 : ~line_act[k];
         d.lamp[k]  = ~d.irq_n[k];
      end
      d.lamp[fia_pkg::LINE_SYS] = ~d.irq_n[fia_pkg::LINE_SYS] | d.led_force;

      if (addr_ok && !hwrite) begin
         case (haddr[7:2])
            fia_pkg::IDX_INVA_STAT: d.hrdata = {28'h0, d.inva_stat};
            fia_pkg::IDX_INVA_EN:   d.hrdata = {28'h0, d.inva_en};
            fia_pkg::IDX_INVB_STAT: d.hrdata = {28'h0, d.invb_stat};
            fia_pkg::IDX_INVB_EN:   d.hrdata = {28'h0, d.invb_en};
            fia_pkg::IDX_HB_STAT:   d.hrdata = {30'h0, d.hb_stat};
            fia_pkg::IDX_HB_EN:     d.hrdata = {30'h0, d.hb_en};
            fia_pkg::IDX_SYS_STAT:  d.hrdata = {27'h0, d.sys_stat};
            fia_pkg::IDX_SYS_EN:    d.hrdata = {27'h0, d.sys_en};
            fia_pkg::IDX_LED_CTRL:  d.hrdata = {31'h0, d.led_force};
            fia_pkg::IDX_SRC_LEVEL: d.hrdata = {17'h0, flt_lvl};
            default:                d.hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   assign hreadyout              = q.hreadyout;
   assign hresp                  = 1'b0;
   assign hrdata                 = q.hrdata;
   assign inva_irq_out_n         = q.irq_n[fia_pkg::LINE_INVA];
   assign invb_irq_out_n         = q.irq_n[fia_pkg::LINE_INVB];
   assign half_bridge_irq_out_n  = q.irq_n[fia_pkg::LINE_HB];
   assign sys_irq_out_n          = q.irq_n[fia_pkg::LINE_SYS];
   assign inva_fault_lamp        = q.lamp[fia_pkg::LINE_INVA];
   assign invb_fault_lamp        = q.lamp[fia_pkg::LINE_INVB];
   assign half_bridge_fault_lamp = q.lamp[fia_pkg::LINE_HB];
   assign sys_fault_lamp         = q.lamp[fia_pkg::LINE_SYS];

   // Checks on the latching and interrupt behaviour.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_clear_inva;
      q.wr_pend && q.wr_idx == fia_pkg::IDX_INVA_STAT && (|(q.inva_stat & ~hwdata[3:0]));
   endsequence

   sequence s_clear_hb;
      q.wr_pend && q.wr_idx == fia_pkg::IDX_HB_STAT && (|(q.hb_stat & ~hwdata[1:0]));
   endsequence

   a_release_inva: assert property (s_clear_inva |=> inva_irq_out_n)
      else $error("First inverter line not released after a clear.");

   a_release_hb: assert property (s_clear_hb |=> half_bridge_irq_out_n)
      else $error("Half bridge line not released after a clear.");

   a_irq_enabled: assert property (
      (|(q.inva_stat & q.inva_en)) && q.rel_cnt[0] == 2'h0 |-> !inva_irq_out_n)
      else $error("First inverter line high with an enabled fault pending.");

   a_irq_gated: assert property (
      !(|(q.sys_stat & q.sys_en)) |-> sys_irq_out_n)
      else $error("System line low with no enabled source.");

   a_lamp_inverse: assert property (
      inva_fault_lamp == !inva_irq_out_n && invb_fault_lamp == !invb_irq_out_n
      && half_bridge_fault_lamp == !half_bridge_irq_out_n)
      else $error("Fault lamp differs from its interrupt line.");

   a_lamp_forced: assert property (
      sys_fault_lamp == (!sys_irq_out_n || q.led_force))
      else $error("System lamp wrong for force bit and line.");

   a_inva_latch: assert property (
      inva_ev != 4'h0 |=> (q.inva_stat & $past(inva_ev)) == $past(inva_ev))
      else $error("First inverter fault not latched.");

   a_invb_latch: assert property (
      invb_ev != 4'h0 |=> (q.invb_stat & $past(invb_ev)) == $past(invb_ev))
      else $error("Second inverter fault not latched.");

   a_hb_latch: assert property (hb_ev != 2'h0 |=> q.hb_stat != 2'h0)
      else $error("Half bridge fault not latched.");

   a_relay_low: assert property (
      flt_chg[fia_pkg::SRC_RLY_BIT] && !flt_lvl[fia_pkg::SRC_RLY_BIT]
      |=> q.sys_stat[fia_pkg::SYS_RLY_BIT])
      else $error("Relay fault falling edge not latched.");

   a_gpi_edge: assert property (
      flt_chg[fia_pkg::SRC_GPI_LSB] |=> q.sys_stat[fia_pkg::SYS_GPI_LSB])
      else $error("Input transition not latched.");

   a_stat_sticky: assert property (
      q.inva_stat[0] && !(q.wr_pend && q.wr_idx == fia_pkg::IDX_INVA_STAT)
      |=> q.inva_stat[0])
      else $error("Status bit dropped without a clear.");

   a_reset_quiet: assert property (@(posedge clk) $fell(rst) |->
      q.inva_en == 4'h0 && q.sys_en == 5'h00 && sys_irq_out_n)
      else $error("Enables or line not idle after reset.");

endmodule : fia_fault_aggregator

// [sim/fia_host_model.sv]
// Host side of the interrupt lines: counts falling edges on each of the four lines.
// Assumes the lines are sampled on the same clock that runs the aggregator.
`timescale 1ns/1ps
module fia_host_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [3:0]  irq_n,
   output logic      [15:0] fall_cnt
);
   logic [3:0] prev_r;

   // Each line is edge triggered; a count of four bits per line is kept.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_r   <= 4'hF;
         fall_cnt <= 16'h0000;
      end else begin
         prev_r <= irq_n;
         for (int k = 0; k < 4; k++) begin
            if (prev_r[k] && !irq_n[k]) begin
               fall_cnt[4*k +: 4] <= fall_cnt[4*k +: 4] + 4'h1;
            end
         end
      end
   end
endmodule : fia_host_model

// [sim/testbench.sv]
// Self-checking bench for the fault interrupt aggregator.
// Assumes the package, the design and the host model are compiled first.
`timescale 1ns/1ps
module testbench;
   logic        clk    = 1'b0;
   logic        rst    = 1'b1;
   logic        hsel   = 1'b0;
   logic [7:0]  haddr  = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h00000000;
   logic [14:0] src    = 15'h0000;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [3:0]  irq_n;
   logic [3:0]  lamp;
   logic [15:0] falls;
   int          failures   = 0;
   int          n_compared = 0;

   always #20 clk = ~clk;

   fia_fault_aggregator u_fia_fault_aggregator (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .inva_ovt(src[0]), .inva_err_w(src[1]), .inva_err_v(src[2]), .inva_err_u(src[3]),
      .invb_ovt(src[4]), .invb_err_w(src[5]), .invb_err_v(src[6]), .invb_err_u(src[7]),
      .hb_ovt(src[8]), .hb_err(src[9]), .relay_fault_n(~src[10]), .gpi(src[14:11]),
      .inva_irq_out_n(irq_n[0]), .invb_irq_out_n(irq_n[1]),
      .half_bridge_irq_out_n(irq_n[2]), .sys_irq_out_n(irq_n[3]),
      .inva_fault_lamp(lamp[0]), .invb_fault_lamp(lamp[1]),
      .half_bridge_fault_lamp(lamp[2]), .sys_fault_lamp(lamp[3])
   );

   fia_host_model u_fia_host_model (
      .clk(clk), .rst(rst), .irq_n(irq_n), .fall_cnt(falls)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : wait_cyc

   task automatic wait_rdy;
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         @(posedge clk);
      end
   endtask : wait_rdy

   // One single word transfer; read data is taken at the edge ending the data phase.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
      chk(32'(hresp), 32'h0);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask : rd

   task automatic pulse(input int i, input int n);
      @(posedge clk);
      src[i] <= 1'b1;
      repeat (n) @(posedge clk);
      src[i] <= 1'b0;
      wait_cyc(10);
   endtask : pulse

   task automatic t_reset;
      for (int k = 0; k < 8; k++) rd(8'(4 * k), 32'h0);
      chk(32'(irq_n), 32'hF);
      chk(32'(lamp), 32'h0);
      rd(8'hC4, 32'(fia_pkg::SRC_IDLE));
      wr(8'h40, 32'hFFFFFFFF);
      rd(8'h40, 32'h0);
      wr(8'h04, 32'hFFFFFFFF);
      rd(8'h04, 32'hF);
      wr(8'h04, 32'h0);
      $display("test reset_and_map done");
   endtask : t_reset

   task automatic t_route;
      int ln;
      int b;
      for (int i = 0; i < 15; i++) begin
         ln = (i < 4) ? 0 : (i < 8) ? 1 : (i < 10) ? 2 : 3;
         b  = (i < 8) ? i % 4 : (i < 10) ? i - 8 : i - 10;
         pulse(i, 12);
         rd(8'(8 * ln), 32'h1 << b);
         chk(32'(irq_n), 32'hF);
         wr(8'(8 * ln + 4), 32'h1F);
         wait_cyc(2);
         chk(32'(irq_n), 32'hF ^ (32'h1 << ln));
         chk(32'(lamp), 32'h1 << ln);
         wr(8'(8 * ln + 4), 32'h0);
         wr(8'(8 * ln), 32'h0);
         rd(8'(8 * ln), 32'h0);
      end
      chk(32'(falls), 32'h5244);
      $display("test routing done");
   endtask : t_route

   task automatic t_glitch;
      pulse(9, 2);
      rd(8'h10, 32'h0);
      pulse(9, 4);
      rd(8'h10, 32'h2);
      wr(8'h10, 32'h0);
      $display("test filter done");
   endtask : t_glitch

   task automatic t_irq;
      wr(8'h04, 32'hF);
      @(posedge clk);
      src[0] <= 1'b1;
      src[3] <= 1'b1;
      wait_cyc(10);
      chk(32'(irq_n), 32'hE);
      chk(32'(lamp), 32'h1);
      chk(32'(falls), 32'h5245);
      wr(8'h00, 32'hE);
      wait_cyc(3);
      chk(32'(falls), 32'h5246);
      rd(8'h00, 32'h8);
      chk(32'(irq_n), 32'hE);
      wr(8'h04, 32'h7);
      wait_cyc(2);
      chk(32'(irq_n), 32'hF);
      chk(32'(lamp), 32'h0);
      rd(8'h00, 32'h8);
      @(posedge clk);
      src[0] <= 1'b0;
      src[3] <= 1'b0;
      wait_cyc(10);
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      $display("test interrupt done");
   endtask : t_irq

   task automatic t_lamp;
      wr(8'hC0, 32'h1);
      wait_cyc(2);
      chk(32'(lamp), 32'h8);
      chk(32'(irq_n), 32'hF);
      rd(8'hC0, 32'h1);
      wr(8'hC0, 32'h0);
      wait_cyc(2);
      chk(32'(lamp), 32'h0);
      $display("test lamp done");
   endtask : t_lamp

   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      close_out();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_route();
      t_glitch();
      t_irq();
      t_lamp();
      close_out();
   end
endmodule : testbench
